//--- design/anr_regs.sv
`timescale 1ns/1ps
// What this block does
// - Local advertisement bit 14 reads zero and ignores writes.
// - Local bit 13 advertises a detected far fault; writable, resets zero.
// - Local bit 12 is reserved and reads zero.
// - Local bit 11 advertises asymmetric pause; writable, resets zero.
// - Local bit 10 advertises symmetric pause; writable, resets zero.
// - Resolved pause outcome is driven on the 2-bit pause_resolution output.
// - Local bit 9, four-pair ability, is read-only zero.
// - Local bits 8:5 are writable technology abilities resetting to one.
// - Local bits 4:0 hold a writable selector resetting to 00001.
// - Partner register captures received pages, replaced by next pages later.
// - Partner bit 15 shows the partner wants next pages.
// - Partner bit 14 shows partner acknowledge from negotiation logic.
// - Partner bits 13:5 mirror partner fault, pause and technology bits.
// - Partner bits 4:0 hold the received selector, reset zero.
// - Expansion bits 15:5 read zero; writes ignored.
// - Expansion bit 4 is set on a parallel detection fault.
// - Expansion bit 3 shows partner next page support.
// - Expansion bit 2 is a constant one.
// - Expansion bit 1 sets on page receipt, cleared by a read.
// - Expansion bit 0 shows partner negotiation ability.
// - Next-page transmit bit 15 is writable, resets zero.
// - Local bit 15 is writable next page request, resets zero.
module anr_regs (
    input wire logic ref_clk,
    input wire logic resetn,
    // Management access, already decoded from the serial frames
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_hit,
    // Negotiation state machine on the line side
    input wire logic page_rx_stb,
    input wire logic [15:0] page_rx_word,
    input wire logic partner_ack,
    input wire logic parallel_detect_fault,
    input wire logic partner_negotiation_capable,
    input wire logic negotiation_done,
    // Transmitted base page and next page word
    output logic [15:0] tx_base_page,
    output logic [15:0] tx_next_page,
    output logic [1:0] pause_resolution
);
    import anr_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    logic rst_n;
    assign rst_n = rst_sync_q;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        hit = (a == r);
    endfunction : hit

    logic wr_local;
    logic wr_np;
    logic rd_exp;
    assign wr_local = mgmt_wr && hit(mgmt_addr, ANR_ADDR_LOCAL);
    assign wr_np = mgmt_wr && hit(mgmt_addr, ANR_ADDR_NEXT_PAGE);
    assign rd_exp = mgmt_rd && hit(mgmt_addr, ANR_ADDR_EXPANSION);

    // ------------------------------------------------------------
    // Local advertisement
    // ------------------------------------------------------------
    logic next_page_wanted_q;
    logic far_fault_flag_q;
    logic asymmetric_flow_stop_q;
    logic sym_pause_q;
    logic [3:0] tech_q;
    logic [4:0] selector_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            next_page_wanted_q <= 1'b0;
        end else if (wr_local) begin
            next_page_wanted_q <= mgmt_wdata[ANR_BIT_NP];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            far_fault_flag_q <= 1'b0;
        end else if (wr_local) begin
            far_fault_flag_q <= mgmt_wdata[ANR_BIT_RF];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            asymmetric_flow_stop_q <= 1'b0;
        end else if (wr_local) begin
            asymmetric_flow_stop_q <= mgmt_wdata[ANR_BIT_ASYM];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sym_pause_q <= 1'b0;
        end else if (wr_local) begin
            sym_pause_q <= mgmt_wdata[ANR_BIT_PAUSE];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tech_q <= ANR_TECH_RESET;
        end else if (wr_local) begin
            tech_q <= mgmt_wdata[ANR_BIT_TECH_HI:ANR_BIT_TECH_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            selector_q <= ANR_SEL_RESET;
        end else if (wr_local) begin
            selector_q <= mgmt_wdata[ANR_BIT_SEL_HI:0];
        end
    end

    logic [15:0] local_word;
    // Bits 14, 12 and 9 are tied low: no storage behind them
    always_comb begin
        local_word = 16'h0000;
        local_word[ANR_BIT_NP] = next_page_wanted_q;
        local_word[ANR_BIT_RF] = far_fault_flag_q;
        local_word[ANR_BIT_ASYM] = asymmetric_flow_stop_q;
        local_word[ANR_BIT_PAUSE] = sym_pause_q;
        local_word[ANR_BIT_TECH_HI:ANR_BIT_TECH_LO] = tech_q;
        local_word[ANR_BIT_SEL_HI:0] = selector_q;
    end

    // ------------------------------------------------------------
    // Partner ability
    // ------------------------------------------------------------
    logic [15:0] partner_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_q <= 16'h0000;
        end else if (page_rx_stb) begin
            // Later next pages overwrite the base page by design
            partner_q <= page_rx_word;
        end
    end

    logic [15:0] partner_word;
    always_comb begin
        partner_word = partner_q;
        partner_word[ANR_BIT_ACK] = partner_ack;
    end

    // ------------------------------------------------------------
    // Expansion status
    // ------------------------------------------------------------
    logic pdf_q;
    logic partner_np_q;
    logic page_rx_q;
    logic lp_an_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pdf_q <= 1'b0;
        end else begin
            pdf_q <= parallel_detect_fault;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_an_q <= 1'b0;
        end else begin
            lp_an_q <= partner_negotiation_capable;
        end
    end

    // Follows the most recent page, so a later next page may change it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_np_q <= 1'b0;
        end else if (page_rx_stb) begin
            partner_np_q <= page_rx_word[ANR_BIT_NP];
        end
    end

    // A page arriving in the read cycle survives: set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_rx_q <= 1'b0;
        end else if (page_rx_stb) begin
            page_rx_q <= 1'b1;
        end else if (rd_exp) begin
            page_rx_q <= 1'b0;
        end
    end

    logic [15:0] exp_word;
    always_comb begin
        exp_word = 16'h0000;
        exp_word[ANR_EXP_PDF] = pdf_q;
        exp_word[ANR_EXP_LP_NP] = partner_np_q;
        exp_word[ANR_EXP_LOCAL_NEXT_PAGE_CAPABLE] = 1'b1;
        exp_word[ANR_EXP_PAGE_RX] = page_rx_q;
        exp_word[ANR_EXP_LP_AN] = lp_an_q;
    end

    // ------------------------------------------------------------
    // Next page transmit (only the continuation bit lives here)
    // ------------------------------------------------------------
    logic np_more_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            np_more_q <= ANR_NP_TX_RESET[ANR_BIT_NP];
        end else if (wr_np) begin
            np_more_q <= mgmt_wdata[ANR_BIT_NP];
        end
    end
    logic [15:0] np_word;
    always_comb begin
        np_word = 16'h0000;
        np_word[ANR_BIT_NP] = np_more_q;
    end

    // ------------------------------------------------------------
    // Read mux; data registered for the serial shifter
    // ------------------------------------------------------------
    logic [15:0] rdata_d;
    logic hit_d;
    always_comb begin
        hit_d = 1'b1;
        case (mgmt_addr)
            ANR_ADDR_LOCAL: rdata_d = local_word;
            ANR_ADDR_PARTNER: rdata_d = partner_word;
            ANR_ADDR_EXPANSION: rdata_d = exp_word;
            ANR_ADDR_NEXT_PAGE: rdata_d = np_word;
            default: begin
                rdata_d = 16'h0000;
                hit_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_rd) begin
            mgmt_rdata <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_hit <= 1'b0;
        end else if (mgmt_rd) begin
            mgmt_hit <= hit_d;
        end
    end

    // ------------------------------------------------------------
    // Line side outputs and pause resolution
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_base_page <= 16'h0000;
        end else begin
            tx_base_page <= local_word;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_next_page <= 16'h0000;
        end else begin
            tx_next_page <= np_word;
        end
    end

    anr_pause_e pause_now;
    anr_pause_resolve u_pause (
        .local_sym(sym_pause_q),
        .local_asym(asymmetric_flow_stop_q),
        .partner_sym(partner_q[ANR_BIT_PAUSE]),
        .partner_asym(partner_q[ANR_BIT_ASYM]),
        .outcome(pause_now)
    );

    // Held until negotiation completes so software never sees a half result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_resolution <= ANR_PAUSE_NONE;
        end else if (negotiation_done) begin
            pause_resolution <= pause_now;
        end
    end

endmodule : anr_regs

//--- design/anr_pkg.sv
package anr_pkg;

    // ------------------------------------------------------------
    // Register addresses on the management interface
    // ------------------------------------------------------------
    localparam logic [4:0] ANR_ADDR_LOCAL = 5'h04;
    localparam logic [4:0] ANR_ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ANR_ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ANR_ADDR_NEXT_PAGE = 5'h07;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ANR_BIT_NP = 15;
    localparam int ANR_BIT_ACK = 14;
    localparam int ANR_BIT_RF = 13;
    localparam int ANR_BIT_RSVD12 = 12;
    localparam int ANR_BIT_ASYM = 11;
    localparam int ANR_BIT_PAUSE = 10;
    localparam int ANR_BIT_T4 = 9;
    localparam int ANR_BIT_TECH_HI = 8;
    localparam int ANR_BIT_TECH_LO = 5;
    localparam int ANR_BIT_SEL_HI = 4;

    localparam int ANR_EXP_PDF = 4;
    localparam int ANR_EXP_LP_NP = 3;
    localparam int ANR_EXP_LOCAL_NEXT_PAGE_CAPABLE = 2;
    localparam int ANR_EXP_PAGE_RX = 1;
    localparam int ANR_EXP_LP_AN = 0;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [3:0] ANR_TECH_RESET = 4'hf;
    localparam logic [4:0] ANR_SEL_RESET = 5'h01;
    // Bits of the local advertisement that software may change
    localparam logic [15:0] ANR_LOCAL_WMASK = 16'hadff;
    localparam logic [15:0] ANR_NP_TX_RESET = 16'h0000;

    // Pause resolution codes driven on the pause_resolution output
    typedef enum logic [1:0] {
        ANR_PAUSE_NONE = 2'h0,
        ANR_PAUSE_RX = 2'h1,
        ANR_PAUSE_TX = 2'h2,
        ANR_PAUSE_BOTH = 2'h3
    } anr_pause_e;

endpackage : anr_pkg

//--- design/anr_pause_resolve.sv
`timescale 1ns/1ps
// Pause resolution of the local and partner pause ability bits.
module anr_pause_resolve (
    input wire logic local_sym,
    input wire logic local_asym,
    input wire logic partner_sym,
    input wire logic partner_asym,
    output anr_pkg::anr_pause_e outcome
);
    import anr_pkg::*;

    always_comb begin
        if (local_sym && partner_sym) begin
            outcome = ANR_PAUSE_BOTH;
        end else if (local_sym && local_asym && !partner_sym && partner_asym) begin
            outcome = ANR_PAUSE_RX;
        end else if (!local_sym && local_asym && partner_sym && partner_asym) begin
            outcome = ANR_PAUSE_TX;
        end else begin
            outcome = ANR_PAUSE_NONE;
        end
    end

endmodule : anr_pause_resolve

//--- testbench/anr_regs_properties.sv
`timescale 1ns/1ps
module anr_regs_properties
    import anr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_hit,
    input wire logic page_rx_stb,
    input wire logic partner_ack,
    input wire logic [15:0] tx_base_page,
    input wire logic [15:0] tx_next_page
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic wr4, rd5, rd6, unmap;
    assign wr4 = mgmt_wr && mgmt_addr == ANR_ADDR_LOCAL;
    assign rd5 = mgmt_rd && mgmt_addr == ANR_ADDR_PARTNER;
    assign rd6 = mgmt_rd && mgmt_addr == ANR_ADDR_EXPANSION;
    assign unmap = mgmt_rd && (mgmt_addr < 5'h04 || mgmt_addr > 5'h07);
    property p_local_rsvd; !tx_base_page[14] && !tx_base_page[12] && !tx_base_page[9]; endproperty
    a_local_rsvd: assert property (p_local_rsvd) else $error("reserved advert bit set");
    property p_np_tx; tx_next_page[14:0] == 15'h0000; endproperty
    a_np_tx: assert property (p_np_tx) else $error("next page word low bits set");
    property p_local_wr;
        wr4 ##1 !wr4 |=> tx_base_page == ($past(mgmt_wdata, 2) & 16'hadff);
    endproperty
    a_local_wr: assert property (p_local_wr) else $error("base page not written");
    property p_exp_rsvd; rd6 |=> mgmt_rdata[15:5] == 11'h000; endproperty
    a_exp_rsvd: assert property (p_exp_rsvd) else $error("expansion high bits set");
    property p_local_next_page_capable; rd6 |=> mgmt_rdata[2]; endproperty
    a_local_next_page_capable: assert property (p_local_next_page_capable) else $error("next page able low");
    property p_unmapped; unmap |=> mgmt_rdata == 16'h0000 && !mgmt_hit; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_ack_live; rd5 |=> mgmt_rdata[14] == $past(partner_ack); endproperty
    a_ack_live: assert property (p_ack_live) else $error("partner ack bit wrong");
    property p_page_set; page_rx_stb ##1 !rd6 [*3] ##1 rd6 |=> mgmt_rdata[1]; endproperty
    a_page_set: assert property (p_page_set) else $error("page received not set");
    property p_read_clr; rd6 && !page_rx_stb ##1 (!page_rx_stb) [*2] ##0 rd6 |=> !mgmt_rdata[1];
    endproperty
    a_read_clr: assert property (p_read_clr) else $error("page received not cleared");
    property p_hold; !mgmt_rd |=> $stable(mgmt_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");
    c_page: cover property (page_rx_stb ##[1:4] rd6);
    c_unmap: cover property (unmap);
    c_clear: cover property (rd6 ##2 rd6);
endmodule : anr_regs_properties

bind anr_regs anr_regs_properties u_props (
    .ref_clk(ref_clk), .resetn(resetn), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_hit(mgmt_hit), .page_rx_stb(page_rx_stb), .partner_ack(partner_ack),
    .tx_base_page(tx_base_page), .tx_next_page(tx_next_page)
);

//--- testbench/anr_mgmt_master.sv
`timescale 1ns/1ps
module anr_mgmt_master (
    input wire logic ref_clk,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [4:0] mgmt_addr,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_hit
);
    initial begin
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // Idle address and data are inverted so stale values never look valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        mgmt_wr <= 1'b1;
        mgmt_addr <= a;
        mgmt_wdata <= d;
        @(posedge ref_clk);
        mgmt_wr <= 1'b0;
        mgmt_addr <= ~a;
        mgmt_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic h);
        @(posedge ref_clk);
        mgmt_rd <= 1'b1;
        mgmt_addr <= a;
        @(posedge ref_clk);
        mgmt_rd <= 1'b0;
        mgmt_addr <= ~a;
        #1;
        d = mgmt_rdata;
        h = mgmt_hit;
    endtask : rd
endmodule : anr_mgmt_master

//--- testbench/test_autoneg_ability_registers.sv
`timescale 1ns/1ps
module test_autoneg_ability_registers;
    import anr_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic mgmt_wr, mgmt_rd, mgmt_hit, rd_h;
    logic page_rx_stb = 1'b0, partner_ack = 1'b0, negotiation_done = 1'b0;
    logic parallel_detect_fault = 1'b0, partner_negotiation_capable = 1'b0;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, tx_base_page, tx_next_page, rd_d, loc, par, xw;
    logic [15:0] page_rx_word = 16'h0000;
    logic [1:0] pause_resolution;
    int error_cnt = 0, n_compared = 0, seed = 73, cyc = 0;
    always #5 ref_clk = ~ref_clk;
    anr_regs DUT (.ref_clk(ref_clk), .resetn(resetn), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_hit(mgmt_hit), .page_rx_stb(page_rx_stb), .page_rx_word(page_rx_word),
        .partner_ack(partner_ack), .parallel_detect_fault(parallel_detect_fault),
        .partner_negotiation_capable(partner_negotiation_capable),
        .negotiation_done(negotiation_done), .tx_base_page(tx_base_page),
        .tx_next_page(tx_next_page), .pause_resolution(pause_resolution));
    anr_mgmt_master u_mst (.ref_clk(ref_clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
        .mgmt_hit(mgmt_hit));
    function automatic logic [1:0] pause_of(input logic [15:0] l, input logic [15:0] p);
        if (l[10] && p[10]) return 2'h3;
        if (!l[10] && l[11] && p[10] && p[11]) return 2'h2;
        if (l[10] && l[11] && !p[10] && p[11]) return 2'h1;
        return 2'h0;
    endfunction : pause_of
    task automatic chk(input logic [15:0] got, input logic [15:0] expv, input string what);
        n_compared++;
        if (got !== expv) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, expv);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a, input logic [15:0] expv);
        u_mst.rd(a, rd_d, rd_h);
        chk(rd_d, expv, "read data");
        chk({15'h0, rd_h}, {15'h0, a >= 5'h04 && a <= 5'h07}, "hit");
    endtask : rchk
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: run did not finish in time", $time);
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rchk(ANR_ADDR_LOCAL, 16'h01e1);
        rchk(ANR_ADDR_PARTNER, 16'h0000);
        rchk(ANR_ADDR_EXPANSION, 16'h0004);
        rchk(ANR_ADDR_NEXT_PAGE, 16'h0000);
        rchk(5'h1f, 16'h0000);
        u_mst.wr(ANR_ADDR_LOCAL, 16'hffff);
        rchk(ANR_ADDR_LOCAL, 16'hadff);
        u_mst.wr(ANR_ADDR_EXPANSION, 16'hffff);
        u_mst.wr(ANR_ADDR_PARTNER, 16'hffff);
        u_mst.wr(ANR_ADDR_NEXT_PAGE, 16'hffff);
        rchk(ANR_ADDR_EXPANSION, 16'h0004);
        rchk(ANR_ADDR_PARTNER, 16'h0000);
        rchk(ANR_ADDR_NEXT_PAGE, 16'h8000);
        chk(tx_next_page, 16'h8000, "next page");
        for (int i = 0; i < 24; i++) begin
            loc = 16'($random(seed));
            u_mst.wr(ANR_ADDR_LOCAL, loc);
            loc = loc & 16'hadff;
            @(posedge ref_clk);
            page_rx_word <= 16'($random(seed));
            partner_ack <= 1'($random(seed));
            parallel_detect_fault <= 1'($random(seed));
            partner_negotiation_capable <= 1'($random(seed));
            page_rx_stb <= 1'b1;
            @(posedge ref_clk);
            page_rx_stb <= 1'b0;
            par = page_rx_word;
            chk(tx_base_page, loc, "base page");
            rchk(ANR_ADDR_PARTNER, {par[15], partner_ack, par[13:0]});
            xw = {11'h000, parallel_detect_fault, par[15], 2'h3, partner_negotiation_capable};
            rchk(ANR_ADDR_EXPANSION, xw);
            xw[ANR_EXP_PAGE_RX] = 1'b0;
            rchk(ANR_ADDR_EXPANSION, xw);
            @(posedge ref_clk);
            negotiation_done <= 1'b1;
            repeat (3) @(posedge ref_clk);
            negotiation_done <= 1'b0;
            #1;
            chk({14'h0, pause_resolution}, {14'h0, pause_of(loc, par)}, "pause");
        end
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rchk(ANR_ADDR_LOCAL, 16'h01e1);
        rchk(ANR_ADDR_PARTNER, {1'b0, partner_ack, 14'h0000});
        rchk(ANR_ADDR_NEXT_PAGE, 16'h0000);
        report_and_stop();
    end
endmodule : test_autoneg_ability_registers
